// [inc/mcp_pkg.sv]
// Constants for the metering configuration and protection bank
`default_nettype none
package mcp_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   // Register addresses
   localparam logic [15:0] ADDR_DIE_VERSION = 16'he707;
   localparam logic [15:0] ADDR_PROTECT_CTRL = 16'he7e3;
   localparam logic [15:0] ADDR_UNLOCK_KEY = 16'he7fe;
   localparam logic [15:0] ADDR_GAIN = 16'he60f;
   localparam logic [15:0] ADDR_CONFIG = 16'he618;
   localparam logic [15:0] ADDR_COMP_MODE = 16'he60e;
   localparam logic [15:0] ADDR_PULSE_CFG = 16'he610;
   localparam logic [15:0] ADDR_RUN = 16'he228;
   localparam logic [15:0] ADDR_LAST_ADDR = 16'he9fe;
   localparam logic [15:0] ADDR_LAST_DATA = 16'he9ff;
   localparam logic [15:0] ADDR_ENERGY_BASE = 16'he400;
   localparam logic [15:0] ADDR_RAM_BASE = 16'h4380;
   localparam logic [15:0] ADDR_INTEG_COEFF = 16'h4388;
   localparam logic [15:0] ADDR_WAVE_FIRST = 16'he880;
   localparam logic [15:0] ADDR_WAVE_LAST = 16'he89f;
   // Key and protection codes
   localparam logic [7:0] UNLOCK_KEY = 8'had;
   localparam logic [7:0] PROTECT_ON = 8'h80;
   localparam logic [7:0] PROTECT_OFF = 8'h00;
   localparam logic [23:0] INTEG_COEFF_RECOMMENDED = 24'hff8000;
   // Field positions
   localparam int GAIN_PHASE_LSB = 0;
   localparam int GAIN_NEUTRAL_LSB = 3;
   localparam int GAIN_VOLTAGE_LSB = 6;
   localparam int GAIN_FIELD_W = 3;
   localparam int CONFIG_INTEG_EN_BIT = 0;
   localparam int COMP_LINE_FREQ_BIT = 14;
   localparam int PULSE_DIS_LSB = 9;
   localparam int PULSE_COUNT = 3;
   localparam int ENERGY_COUNT = 4;
   // Reset values
   localparam logic [15:0] GAIN_RESET = 16'h0000;
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [15:0] COMP_MODE_RESET = 16'h0000;
   localparam logic [15:0] PULSE_CFG_RESET = 16'h0e00;
endpackage
`default_nettype wire

// [logic/mcp_bank.sv]
// Configuration, protection and last-access register bank
//
// Overview of operation
// - Key then 0x80 enables RAM protection
// - Key then 0x00 removes RAM protection
// - Energy registers clear on read
// - Pulse outputs enabled by clearing bits 9-11
// - Read-only die version at 0xE707
// - Reads record address and data
// - Burst SPI waveform reads record address plus one
// - Gain fields at bits 2:0, 5:3, 8:6
`timescale 1ns/1ps
`default_nettype none
module mcp_bank
   import mcp_pkg::*;
#(
   parameter logic [7:0] DIE_VERSION = 8'h5a, // Arbitrary value
   parameter int RAM_DEPTH = 16,
   parameter int WAVE_COUNT = 32,
   parameter int ENERGY_W = 32
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Register access from the serial interface
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic i_burst_spi,
   input wire logic [mcp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [mcp_pkg::DATA_W-1:0] i_wdata,
   output logic [mcp_pkg::DATA_W-1:0] o_rdata,
   output logic o_rvalid,
   // Measurement inputs
   input wire logic [WAVE_COUNT-1:0][23:0] i_waveform,
   input wire logic [mcp_pkg::ENERGY_COUNT-1:0] i_energy_step,
   // Control outputs
   output logic [2:0] o_phase_current_gain_sel,
   output logic [2:0] o_neutral_current_gain_sel,
   output logic [2:0] o_voltage_gain_sel,
   output logic o_integrator_enable,
   output logic o_line_frequency_select,
   output logic [mcp_pkg::PULSE_COUNT-1:0] o_pulse_enable,
   output logic o_dsp_run,
   output logic o_ram_protected
);
   import mcp_pkg::*;

   localparam int RAM_IDX_W = $clog2(RAM_DEPTH);

   logic [15:0] gain_q;
   logic [15:0] config_q;
   logic [15:0] comp_mode_q;
   logic [15:0] pulse_cfg_q;
   logic run_q;
   logic protect_q;
   logic key_armed_q;
   logic [DATA_W-1:0] ram_q [RAM_DEPTH];
   logic [ADDR_W-1:0] last_addr_q;
   logic [DATA_W-1:0] last_data_q;
   logic [DATA_W-1:0] rdata_q;
   logic rvalid_q;
   logic [ENERGY_COUNT-1:0][ENERGY_W-1:0] energy_value;
   logic [ENERGY_COUNT-1:0] energy_read;
   logic [ADDR_W-1:0] rec_addr;
   logic in_ram;
   logic [RAM_IDX_W-1:0] ram_idx;
   logic [ADDR_W-1:0] ram_off;

   assign ram_off = i_addr - ADDR_RAM_BASE;
   assign in_ram = (i_addr >= ADDR_RAM_BASE) && (ram_off < ADDR_W'(RAM_DEPTH));
   assign ram_idx = ram_off[RAM_IDX_W-1:0];

   // Read data for any address
   function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] v;
      logic [ADDR_W-1:0] off;
      v = '0;
      off = a - ADDR_RAM_BASE;
      if ((a >= ADDR_RAM_BASE) && (off < ADDR_W'(RAM_DEPTH))) begin
         v = ram_q[off[RAM_IDX_W-1:0]];
      end else if ((a >= ADDR_WAVE_FIRST) && (a <= ADDR_WAVE_LAST)) begin
         off = a - ADDR_WAVE_FIRST;
         v = {{(DATA_W-24){i_waveform[off[4:0]][23]}}, i_waveform[off[4:0]]};
      end else if ((a >= ADDR_ENERGY_BASE) && (a < ADDR_ENERGY_BASE + ADDR_W'(ENERGY_COUNT))) begin
         off = a - ADDR_ENERGY_BASE;
         v = DATA_W'(energy_value[off[1:0]]);
      end else begin
         unique case (a)
            ADDR_DIE_VERSION: v = DATA_W'(DIE_VERSION);
            ADDR_PROTECT_CTRL: v = DATA_W'(protect_q ? PROTECT_ON : PROTECT_OFF);
            ADDR_GAIN: v = DATA_W'(gain_q);
            ADDR_CONFIG: v = DATA_W'(config_q);
            ADDR_COMP_MODE: v = DATA_W'(comp_mode_q);
            ADDR_PULSE_CFG: v = DATA_W'(pulse_cfg_q);
            ADDR_RUN: v = DATA_W'(run_q);
            ADDR_LAST_ADDR: v = DATA_W'(last_addr_q);
            ADDR_LAST_DATA: v = last_data_q;
            default: v = '0;
         endcase
      end
      return v;
   endfunction

   // Energy accumulators
   for (genvar g = 0; g < ENERGY_COUNT; g++) begin : g_energy
      assign energy_read[g] = i_rd && (i_addr == ADDR_ENERGY_BASE + ADDR_W'(g));
      mcp_energy_acc #(
         .WIDTH(ENERGY_W)
      ) u_acc (
         .i_clk(i_clk),
         .i_reset_n(i_reset_n),
         .i_step(i_energy_step[g]),
         .i_read(energy_read[g]),
         .o_value(energy_value[g])
      );
   end

   // Configuration registers
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         gain_q <= GAIN_RESET;
         config_q <= CONFIG_RESET;
         comp_mode_q <= COMP_MODE_RESET;
         pulse_cfg_q <= PULSE_CFG_RESET;
         run_q <= 1'b0;
      end else if (i_wr) begin
         unique case (i_addr)
            ADDR_GAIN: gain_q <= i_wdata[15:0];
            ADDR_CONFIG: config_q <= i_wdata[15:0];
            ADDR_COMP_MODE: comp_mode_q <= i_wdata[15:0];
            ADDR_PULSE_CFG: pulse_cfg_q <= i_wdata[15:0];
            ADDR_RUN: run_q <= i_wdata[0];
            default: ;
         endcase
      end
   end

   // Unlock key is armed only for the very next access
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         key_armed_q <= 1'b0;
      end else if (i_wr || i_rd) begin
         key_armed_q <= i_wr && (i_addr == ADDR_UNLOCK_KEY) && (i_wdata[7:0] == UNLOCK_KEY);
      end
   end

   // Protection state
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         protect_q <= 1'b0;
      end else if (i_wr && (i_addr == ADDR_PROTECT_CTRL) && key_armed_q) begin
         if (i_wdata[7:0] == PROTECT_ON) begin
            protect_q <= 1'b1;
         end else if (i_wdata[7:0] == PROTECT_OFF) begin
            protect_q <= 1'b0;
         end
      end
   end

   // Data memory RAM, writes blocked while protected
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         for (int i = 0; i < RAM_DEPTH; i++) begin
            ram_q[i] <= '0;
         end
      end else if (i_wr && in_ram && !protect_q) begin
         ram_q[ram_idx] <= i_wdata;
      end
   end

   // Burst SPI waveform reads record the following address
   always_comb begin
      rec_addr = i_addr;
      if (i_burst_spi && (i_addr >= ADDR_WAVE_FIRST) && (i_addr <= ADDR_WAVE_LAST)) begin
         rec_addr = i_addr + ADDR_W'(1);
      end
   end

   // Last-access verification registers
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         last_addr_q <= '0;
         last_data_q <= '0;
      end else if (i_rd) begin
         last_addr_q <= rec_addr;
         last_data_q <= read_mux(rec_addr);
      end
   end

   // Read answer one cycle after the request
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= i_rd;
         if (i_rd) begin
            rdata_q <= read_mux(i_addr);
         end
      end
   end

   assign o_rdata = rdata_q;
   assign o_rvalid = rvalid_q;
   assign o_phase_current_gain_sel = gain_q[GAIN_PHASE_LSB +: GAIN_FIELD_W];
   assign o_neutral_current_gain_sel = gain_q[GAIN_NEUTRAL_LSB +: GAIN_FIELD_W];
   assign o_voltage_gain_sel = gain_q[GAIN_VOLTAGE_LSB +: GAIN_FIELD_W];
   assign o_integrator_enable = config_q[CONFIG_INTEG_EN_BIT];
   assign o_line_frequency_select = comp_mode_q[COMP_LINE_FREQ_BIT];
   assign o_pulse_enable = ~pulse_cfg_q[PULSE_DIS_LSB +: PULSE_COUNT];
   assign o_dsp_run = run_q;
   assign o_ram_protected = protect_q;
endmodule
`default_nettype wire

// [logic/mcp_energy_acc.sv]
// Energy accumulator that clears when it is read
`timescale 1ns/1ps
`default_nettype none
module mcp_energy_acc #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Energy step and read strobe
   input wire logic i_step,
   input wire logic i_read,
   // Accumulated value
   output logic [WIDTH-1:0] o_value
);
   logic [WIDTH-1:0] acc_q;

   // Step in the read cycle is kept as the first count after the clear
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         acc_q <= '0;
      end else if (i_read) begin
         acc_q <= i_step ? WIDTH'(1) : '0;
      end else if (i_step) begin
         acc_q <= acc_q + WIDTH'(1);
      end
   end

   assign o_value = acc_q;
endmodule
`default_nettype wire

// [sim/mcp_bank_sva.sv]
// Assertions on the bank register port and controls
`timescale 1ns/1ps
`default_nettype none
module mcp_bank_sva
   import mcp_pkg::*;
#(
   parameter logic [7:0] DIE_VERSION = 8'h5a
) (
   // Clock, reset and access
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [mcp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [mcp_pkg::DATA_W-1:0] i_wdata,
   input wire logic [mcp_pkg::ENERGY_COUNT-1:0] i_energy_step,
   // Outputs watched
   input wire logic [mcp_pkg::DATA_W-1:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic [2:0] o_phase_current_gain_sel,
   input wire logic [2:0] o_neutral_current_gain_sel,
   input wire logic [2:0] o_voltage_gain_sel,
   input wire logic [mcp_pkg::PULSE_COUNT-1:0] o_pulse_enable,
   input wire logic o_ram_protected
);
   wire logic key_wr = i_wr && i_addr == ADDR_UNLOCK_KEY && i_wdata[7:0] == UNLOCK_KEY;
   wire logic prot_wr = i_wr && i_addr == ADDR_PROTECT_CTRL;
   wire logic e0_rd = i_rd && i_addr == ADDR_ENERGY_BASE;
   logic last_key_q;

   // Key write was the most recent access, however many idle cycles since
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         last_key_q <= 1'b0;
      end else if (i_rd || i_wr) begin
         last_key_q <= key_wr;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   read_answer_a: assert property (i_rd |=> o_rvalid) else $error("no rvalid");
   quiet_bus_a: assert property (!i_rd |=> !o_rvalid) else $error("stray rvalid");
   version_ro_a: assert property (i_rd && i_addr == ADDR_DIE_VERSION
      |=> o_rdata == {24'h0, DIE_VERSION}) else $error("bad version");
   lock_key_a: assert property (key_wr ##1 !(i_rd || i_wr) ##1 prot_wr && i_wdata[7:0] == PROTECT_ON
      |=> o_ram_protected) else $error("lock missed");
   unlock_key_a: assert property (key_wr ##1 !(i_rd || i_wr) ##1 prot_wr && i_wdata[7:0] == PROTECT_OFF
      |=> !o_ram_protected) else $error("unlock missed");
   keyless_write_a: assert property (prot_wr && !last_key_q
      |=> $stable(o_ram_protected)) else $error("keyless change");
   gain_fields_a: assert property (i_wr && i_addr == ADDR_GAIN
      |=> {o_voltage_gain_sel, o_neutral_current_gain_sel, o_phase_current_gain_sel} == $past(i_wdata[8:0]))
      else $error("gain fields");
   pulse_enable_a: assert property (i_wr && i_addr == ADDR_PULSE_CFG
      |=> o_pulse_enable == ~$past(i_wdata[11:9])) else $error("pulse enable");
   energy_clear_a: assert property (e0_rd && !i_energy_step[0] ##1 !i_energy_step[0] ##1 e0_rd
      |=> o_rdata == 32'h0) else $error("energy kept");
   cover property (o_ram_protected);
   cover property (e0_rd);
   cover property (i_rd && i_addr == ADDR_WAVE_LAST);
endmodule
bind mcp_bank mcp_bank_sva #(.DIE_VERSION(DIE_VERSION)) u_sva (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_rd(i_rd),
   .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .i_energy_step(i_energy_step), .o_rdata(o_rdata),
   .o_rvalid(o_rvalid), .o_phase_current_gain_sel(o_phase_current_gain_sel), .o_pulse_enable(o_pulse_enable),
   .o_neutral_current_gain_sel(o_neutral_current_gain_sel), .o_voltage_gain_sel(o_voltage_gain_sel),
   .o_ram_protected(o_ram_protected));
`default_nettype wire

// [sim/mcp_bank_tb_top.sv]
// Self-checking bench for the configuration and protection bank
`timescale 1ns/1ps
`default_nettype none
module mcp_bank_tb_top;
   import mcp_pkg::*;
   logic i_clk = 0;
   logic i_reset_n = 0;
   logic hrd, hwr, hbs, integ, lfs, run, prot;
   logic [15:0] haddr, a;
   logic [31:0] hwdata, rdata, q;
   logic [31:0][23:0] wave = 0;
   logic [3:0] step = 0;
   logic [2:0] pg, ng, vg, pen;
   logic [8:0] g;
   int failures = 0;
   int check_count = 0;
   int n;
   always #10 i_clk = ~i_clk;
   mcp_host h (.i_clk(i_clk), .o_rd(hrd), .o_wr(hwr), .o_burst(hbs), .o_addr(haddr), .o_wdata(hwdata),
      .i_rdata(rdata));
   mcp_bank #(.DIE_VERSION(8'h3c)) DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_rd(hrd), .i_wr(hwr),
      .i_burst_spi(hbs), .i_addr(haddr), .i_wdata(hwdata), .o_rdata(rdata), .o_rvalid(), .i_waveform(wave),
      .i_energy_step(step), .o_phase_current_gain_sel(pg), .o_neutral_current_gain_sel(ng),
      .o_voltage_gain_sel(vg), .o_integrator_enable(integ), .o_line_frequency_select(lfs),
      .o_pulse_enable(pen), .o_dsp_run(run), .o_ram_protected(prot));
   function automatic logic [31:0] sx(input logic [23:0] v);
      return {{8{v[23]}}, v};
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic put(input logic [15:0] ad, input logic [31:0] d);
      h.acc(1, 0, ad, d, q);
   endtask
   task automatic get(input logic b, input logic [15:0] ad);
      h.acc(0, b, ad, 0, q);
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      end_of_test;
   end
   initial begin
      n = $urandom(32'h1641d17a);
      foreach (wave[i]) wave[i] = $urandom;
      repeat (3) @(posedge i_clk);
      #1;
      i_reset_n = 1;
      chk("pulse_rst", pen, 0);
      put(ADDR_DIE_VERSION, 32'hff);
      get(0, ADDR_DIE_VERSION);
      chk("version", q, 32'h3c);
      repeat (4) begin
         g = $urandom;
         put(ADDR_GAIN, {23'h0, g});
         chk("gains", {vg, ng, pg}, g);
      end
      put(ADDR_INTEG_COEFF, INTEG_COEFF_RECOMMENDED);
      get(0, ADDR_INTEG_COEFF);
      chk("coeff", q, INTEG_COEFF_RECOMMENDED);
      put(ADDR_CONFIG, 1);
      put(ADDR_COMP_MODE, 32'h4000);
      chk("options", {integ, lfs}, 2'b11);
      put(ADDR_PULSE_CFG, 32'h0a00);
      chk("pulse_en", pen, 3'b010);
      $display("test config done");
      n = $urandom;
      h.setup_ram(n);
      h.protect(1);
      chk("locked", prot, 1);
      get(0, ADDR_PROTECT_CTRL);
      chk("prot_read", q, PROTECT_ON);
      for (int i = 0; i < 16; i++) begin
         get(0, ADDR_RAM_BASE + 16'(i));
         chk("ram_verify", q, n + i);
      end
      put(ADDR_RAM_BASE, ~n);
      get(0, ADDR_RAM_BASE);
      chk("ram_kept", q, n);
      put(ADDR_UNLOCK_KEY, UNLOCK_KEY);
      get(0, ADDR_DIE_VERSION);
      put(ADDR_PROTECT_CTRL, PROTECT_OFF);
      chk("keyless", prot, 1);
      put(ADDR_UNLOCK_KEY, UNLOCK_KEY);
      put(ADDR_PROTECT_CTRL, 32'h55);
      chk("bad_code", prot, 1);
      h.protect(0);
      put(ADDR_RAM_BASE, ~n);
      get(0, ADDR_RAM_BASE);
      chk("ram_open", q, ~n);
      $display("test protect done");
      for (int e = 0; e < 4; e++) begin
         n = 1 + $urandom % 7;
         repeat (n) begin
            @(posedge i_clk);
            #1;
            step[e] = 1;
            @(posedge i_clk);
            #1;
            step[e] = 0;
         end
         get(0, ADDR_ENERGY_BASE + 16'(e));
         chk("energy", q, n);
         get(0, ADDR_ENERGY_BASE + 16'(e));
         chk("cleared", q, 0);
      end
      $display("test energy done");
      n = $urandom % 31;
      a = ADDR_WAVE_FIRST + 16'(n);
      for (int k = 0; k < 2; k++) begin
         get(k[0], a);
         get(0, ADDR_LAST_ADDR);
         chk("last_addr", q, a + k);
         get(k[0], a);
         get(0, ADDR_LAST_DATA);
         chk("last_data", q, sx(wave[n + k]));
      end
      get(1, a);
      get(0, ADDR_DIE_VERSION);
      get(0, ADDR_LAST_ADDR);
      chk("last_after", q, ADDR_DIE_VERSION);
      get(1, ADDR_WAVE_LAST);
      get(0, ADDR_LAST_ADDR);
      chk("last_edge_addr", q, ADDR_WAVE_LAST + 16'h1);
      get(1, ADDR_WAVE_LAST);
      get(0, ADDR_LAST_DATA);
      chk("last_edge", q, 0);
      get(0, 16'h1234);
      chk("unmapped", q, 0);
      h.protect(1);
      chk("relocked", prot, 1);
      put(ADDR_RUN, 1);
      chk("run", run, 1);
      $display("test access done");
      end_of_test;
   end
endmodule
`default_nettype wire

// [sim/mcp_host.sv]
// Host model issuing register accesses to the bank
`timescale 1ns/1ps
`default_nettype none
module mcp_host
   import mcp_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Register access
   output logic o_rd = 0,
   output logic o_wr = 0,
   output logic o_burst = 0,
   output logic [15:0] o_addr = 0,
   output logic [31:0] o_wdata = 0,
   input wire logic [31:0] i_rdata
);
   logic [31:0] q;
   task automatic acc(input logic w, input logic b, input logic [15:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge i_clk);
      #1;
      o_wr = w;
      o_rd = !w;
      o_burst = b;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk);
      #1;
      r = i_rdata;
      o_wr = 0;
      o_rd = 0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   task automatic protect(input logic on);
      acc(1, 0, ADDR_UNLOCK_KEY, UNLOCK_KEY, q);
      acc(1, 0, ADDR_PROTECT_CTRL, on ? PROTECT_ON : PROTECT_OFF, q);
   endtask
   task automatic setup_ram(input logic [31:0] v);
      for (int i = 0; i < 16; i++) begin
         acc(1, 0, ADDR_RAM_BASE + 16'(i), v + i, q);
      end
      repeat (2) acc(1, 0, ADDR_RAM_BASE + 16'hf, v + 15, q);
   endtask
endmodule
`default_nettype wire
